//--- logic/cbw_regs.vh
// Register indices, field positions, reset values and decode constants
`ifndef CBW_REGS_VH
`define CBW_REGS_VH

// Register indices; byte address is four times the index
`define CBW_IDX_IOW0_BOT   10'h02C
`define CBW_IDX_IOW0_TOP   10'h030
`define CBW_IDX_IOW1_BOT   10'h034
`define CBW_IDX_IOW1_TOP   10'h038
`define CBW_IDX_IRQ_ROUTE  10'h03C
`define CBW_IDX_IRQ_PIN    10'h03D
`define CBW_IDX_FWD_CTRL   10'h03E
`define CBW_IDX_BRD_VENDOR 10'h040
`define CBW_IDX_BRD_PROD   10'h042
`define CBW_IDX_SYS_CTRL   10'h080

// Reset values
`define CBW_RST_IRQ_ROUTE  8'hFF
`define CBW_RST_FWD_CTRL   16'h0340
`define CBW_RST_BRD_CODE   16'h0000
`define CBW_RST_TIE        1'h0
`define CBW_RST_UNLOCK_N   1'h1

// Forwarding control: writable bits
`define CBW_FWD_WR_MASK    16'h07EF
// Forwarding control field positions
`define CBW_FWD_POST       10
`define CBW_FWD_PREF1      9
`define CBW_FWD_PREF0      8
`define CBW_FWD_IRQSEL     7
`define CBW_FWD_CRST       6
`define CBW_FWD_MABT       5
`define CBW_FWD_VGA        3
`define CBW_FWD_ISA        2
`define CBW_FWD_SERR       1
`define CBW_FWD_PERR       0

// System control field positions
`define CBW_SYS_TIE        29
`define CBW_SYS_LOCK       5

// Interrupt pin codes
`define CBW_PIN_FIRST      8'h01
`define CBW_PIN_SECOND     8'h02

// Legacy ranges
`define CBW_ISA_TOP        16'hFFFF
`define CBW_VGA_IO0_LO     16'h03B0
`define CBW_VGA_IO0_HI     16'h03BB
`define CBW_VGA_IO1_LO     16'h03C0
`define CBW_VGA_IO1_HI     16'h03DF
`define CBW_VGA_MEM_LO     32'h000A0000
`define CBW_VGA_MEM_HI     32'h000BFFFF

`endif

//--- logic/cbw_window_ctrl.v
// Per-socket I/O window, interrupt and bridge control register bank
//
// What this block does
// - Window bottom keeps bits 31..2 writable, bits 1..0 read zero.
// - Bottom upper half is the 64K page, lower half the window bottom.
// - Window top upper half reads zero; page comes from the bottom register.
// - Window top bits 15..2 are writable, doubleword granular.
// - Top comparison treats the two low address bits as ones.
// - A window with bottom and top both zero claims nothing.
// - Windows decide PCI-to-card and card-to-PCI I/O forwarding.
// - Writes to read-only window bits change nothing.
// - Routing byte is read/write storage, reset all ones.
// - Pin byte: 01h for function 0; function 1 gives 02h, or 01h if tied.
// - Control bits 15..11 and 4 read zero; reset value 0340h.
// - Control bit 10 enables write posting for this socket.
// - Control bits 9 and 8 mark memory windows 1 and 0 prefetchable.
// - Control bit 7 routes card interrupts to legacy IRQ instead of PCI.
// - Card reset follows control bit 6 and the PCI reset input.
// - Card master abort reports target abort and SERR only when bit 5 set.
// - Control bit 3 forwards VGA addresses to the card.
// - Control bit 2 blocks last 768 bytes of each 1K in the ISA range.
// - Control bit 1 forwards card system errors to PCI SERR.
// - Control bit 0 reports card parity errors on the parity output.
// - Board codes writable only while the lock bit is zero (default one).
// - Tied interrupts merge both requests onto the first line.
`timescale 1ns/1ps
`include "cbw_regs.vh"

module cbw_window_ctrl #(
    parameter FUNC_NUM = 0
) (
    input  wire        mclk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire        hready_i,
    input  wire [31:0] hwdata_i,
    output wire [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    input  wire        pci_io_valid_i,
    input  wire [31:0] pci_io_addr_i,
    output wire        pci_io_claim_o,
    input  wire        card_io_valid_i,
    input  wire [31:0] card_io_addr_i,
    output wire        card_io_to_pci_o,
    input  wire        pci_mem_valid_i,
    input  wire [31:0] pci_mem_addr_i,
    output wire        pci_mem_vga_claim_o,
    input  wire        int_req_a_i,
    input  wire        int_req_b_i,
    output wire        pci_inta_o,
    output wire        pci_intb_o,
    input  wire        card_func_irq_i,
    output wire        card_irq_to_pci_o,
    output wire        card_irq_to_legacy_o,
    input  wire        pci_reset_input_n_i,
    output wire        card_reset_o,
    input  wire        card_master_abort_i,
    input  wire        serr_enable_i,
    output wire        pci_target_abort_o,
    output wire        pci_serr_o,
    input  wire        card_syserr_n_i,
    input  wire        card_parity_err_n_i,
    output wire        card_parity_report_o,
    output wire        write_post_enable_o,
    output wire        window0_prefetchable_o,
    output wire        window1_prefetchable_o
);

    // Window state: bottom keeps 31..2, top keeps 15..2
    // Only writable bits are stored, so read-only bits cannot change
    reg  [29:0] win_bot_reg [0:1];
    reg  [13:0] win_top_reg [0:1];
    reg  [7:0]  irq_route_reg;
    reg  [15:0] fwd_ctrl_reg;
    reg  [15:0] brd_vendor_reg;
    reg  [15:0] brd_prod_reg;
    reg         tie_reg;
    reg         lock_reg;

    // Bus state
    reg         wr_pend_reg;
    reg         rd_pend_reg;
    reg  [9:0]  idx_reg;
    reg  [31:0] rdata_reg;

    // Synchronisers for pins
    reg  [1:0]  pci_reset_input_sync_reg;
    reg  [1:0]  cserr_sync_reg;
    reg  [1:0]  cperr_sync_reg;

    // Registered outputs
    reg         io_claim_reg;
    reg         io_up_reg;
    reg         mem_vga_reg;
    reg         inta_reg;
    reg         intb_reg;
    reg         irq_pci_reg;
    reg         irq_leg_reg;
    reg         crst_reg;
    reg         tabt_reg;
    reg         serr_reg;
    reg         perr_reg;

    wire [1:0]  pci_win_hit;
    wire [1:0]  card_win_hit;
    wire        addr_phase;
    wire        isa_block;
    wire        vga_io;
    wire [7:0]  pin_value;

    // Window hit with page match and inclusive low-half range
    function win_hit;
        input [31:0] addr;
        input [29:0] bot;
        input [13:0] top;
        begin
            win_hit = ((bot != 30'h00000000) || (top != 14'h0000)) &&
                      (addr[31:16] == bot[29:14]) &&
                      (addr[15:0] >= {bot[13:0], 2'h0}) &&
                      (addr[15:0] <= {top, 2'h3});
        end
    endfunction

    // Address range test for legacy decodes
    // Used for both VGA I/O ranges
    function in_range16;
        input [15:0] a;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range16 = (a >= lo) && (a <= hi);
        end
    endfunction

    // Both windows checked for each direction
    // A card cycle goes up only when no window claims it
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_win
            assign pci_win_hit[g]  = win_hit(pci_io_addr_i, win_bot_reg[g],
                                             win_top_reg[g]);
            assign card_win_hit[g] = win_hit(card_io_addr_i, win_bot_reg[g],
                                             win_top_reg[g]);
        end
    endgenerate

    assign isa_block = fwd_ctrl_reg[`CBW_FWD_ISA] &&
                       (pci_io_addr_i[31:16] == 16'h0000) &&
                       (pci_io_addr_i[9:8] != 2'h0);

    assign vga_io = fwd_ctrl_reg[`CBW_FWD_VGA] &&
                    (pci_io_addr_i[31:16] == 16'h0000) &&
                    (in_range16(pci_io_addr_i[15:0], `CBW_VGA_IO0_LO,
                                `CBW_VGA_IO0_HI) ||
                     in_range16(pci_io_addr_i[15:0], `CBW_VGA_IO1_LO,
                                `CBW_VGA_IO1_HI));

    // pin code by function and tie
    assign pin_value = (FUNC_NUM == 0) ? `CBW_PIN_FIRST :
                       (tie_reg ? `CBW_PIN_FIRST : `CBW_PIN_SECOND);

    // Accepted address phase; the index is captured for the data phase
    assign addr_phase = hsel_i && hready_i && htrans_i[1];

    // Bus answers: reads take one wait state, writes none
    // A read needs a cycle to pick the register from the captured index;
    // writes land at the end of their data phase, so back to back is safe
    assign hreadyout_o = ~rd_pend_reg;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_reg;

    // Read multiplexer on captured index
    // Unmapped indices and reserved bits read as zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (idx_reg)
            `CBW_IDX_IOW0_BOT:   rd_mux = {win_bot_reg[0], 2'h0};
            `CBW_IDX_IOW1_BOT:   rd_mux = {win_bot_reg[1], 2'h0};
            `CBW_IDX_IOW0_TOP:   rd_mux = {16'h0000, win_top_reg[0], 2'h0};
            `CBW_IDX_IOW1_TOP:   rd_mux = {16'h0000, win_top_reg[1], 2'h0};
            `CBW_IDX_IRQ_ROUTE:  rd_mux = {24'h000000, irq_route_reg};
            `CBW_IDX_IRQ_PIN:    rd_mux = {24'h000000, pin_value};
            `CBW_IDX_FWD_CTRL:   rd_mux = {16'h0000, fwd_ctrl_reg};
            `CBW_IDX_BRD_VENDOR: rd_mux = {16'h0000, brd_vendor_reg};
            `CBW_IDX_BRD_PROD:   rd_mux = {16'h0000, brd_prod_reg};
            `CBW_IDX_SYS_CTRL: begin
                rd_mux[`CBW_SYS_TIE]  = tie_reg;
                rd_mux[`CBW_SYS_LOCK] = lock_reg;
            end
            default:             rd_mux = 32'h00000000;
        endcase
    end

    // Bus phase tracking and register writes
    always @(posedge mclk_i) begin
        if (rst_i) begin
            wr_pend_reg    <= 1'b0;
            rd_pend_reg    <= 1'b0;
            idx_reg        <= 10'h000;
            rdata_reg      <= 32'h00000000;
            win_bot_reg[0] <= 30'h00000000;
            win_bot_reg[1] <= 30'h00000000;
            win_top_reg[0] <= 14'h0000;
            win_top_reg[1] <= 14'h0000;
            irq_route_reg  <= `CBW_RST_IRQ_ROUTE;
            fwd_ctrl_reg   <= `CBW_RST_FWD_CTRL;
            brd_vendor_reg <= `CBW_RST_BRD_CODE;
            brd_prod_reg   <= `CBW_RST_BRD_CODE;
            tie_reg        <= `CBW_RST_TIE;
            lock_reg       <= `CBW_RST_UNLOCK_N;
        end else if (ce_i) begin
            if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
                rdata_reg   <= rd_mux;
            end else begin
                wr_pend_reg <= addr_phase && hwrite_i;
                rd_pend_reg <= addr_phase && !hwrite_i;
                if (addr_phase) begin
                    idx_reg <= haddr_i[11:2];
                end
            end
            if (wr_pend_reg) begin
                case (idx_reg)
                    `CBW_IDX_IOW0_BOT: begin
                        win_bot_reg[0] <= hwdata_i[31:2];
                    end
                    `CBW_IDX_IOW1_BOT: begin
                        win_bot_reg[1] <= hwdata_i[31:2];
                    end
                    `CBW_IDX_IOW0_TOP: begin
                        win_top_reg[0] <= hwdata_i[15:2];
                    end
                    `CBW_IDX_IOW1_TOP: begin
                        win_top_reg[1] <= hwdata_i[15:2];
                    end
                    `CBW_IDX_IRQ_ROUTE: begin
                        irq_route_reg <= hwdata_i[7:0];
                    end
                    `CBW_IDX_FWD_CTRL: begin
                        fwd_ctrl_reg <= hwdata_i[15:0] & `CBW_FWD_WR_MASK;
                    end
                    `CBW_IDX_BRD_VENDOR: begin
                        if (!lock_reg) begin
                            brd_vendor_reg <= hwdata_i[15:0];
                        end
                    end
                    `CBW_IDX_BRD_PROD: begin
                        if (!lock_reg) begin
                            brd_prod_reg <= hwdata_i[15:0];
                        end
                    end
                    `CBW_IDX_SYS_CTRL: begin
                        // tie is global; lock guards the board codes
                        tie_reg  <= hwdata_i[`CBW_SYS_TIE];
                        lock_reg <= hwdata_i[`CBW_SYS_LOCK];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Two-flop synchronisers for external pins
    // Pins are active low and inverted on entry so the pipelines
    // clear to the idle level and no false event follows reset
    always @(posedge mclk_i) begin
        if (rst_i) begin
            pci_reset_input_sync_reg  <= 2'h0;
            cserr_sync_reg <= 2'h0;
            cperr_sync_reg <= 2'h0;
        end else if (ce_i) begin
            pci_reset_input_sync_reg  <= {pci_reset_input_sync_reg[0], ~pci_reset_input_n_i};
            cserr_sync_reg <= {cserr_sync_reg[0], ~card_syserr_n_i};
            cperr_sync_reg <= {cperr_sync_reg[0], ~card_parity_err_n_i};
        end
    end

    // Forwarding decisions, one cycle after the request
    // Registering the decisions keeps the compare chains off the outputs;
    // a request seen at one edge is answered after it
    always @(posedge mclk_i) begin
        if (rst_i) begin
            io_claim_reg <= 1'b0;
            io_up_reg    <= 1'b0;
            mem_vga_reg  <= 1'b0;
        end else if (ce_i) begin
            // downstream I/O claim; VGA beats the ISA filter
            io_claim_reg <= pci_io_valid_i &&
                            (((|pci_win_hit) && !isa_block) || vga_io);
            io_up_reg    <= card_io_valid_i && !(|card_win_hit);
            mem_vga_reg  <= pci_mem_valid_i && fwd_ctrl_reg[`CBW_FWD_VGA] &&
                            (pci_mem_addr_i >= `CBW_VGA_MEM_LO) &&
                            (pci_mem_addr_i <= `CBW_VGA_MEM_HI);
        end
    end

    // Interrupt routing and error reporting
    // Card reset is held until the synchronised PCI reset has cleared,
    // so the card never leaves reset while the host is still in it
    always @(posedge mclk_i) begin
        if (rst_i) begin
            inta_reg    <= 1'b0;
            intb_reg    <= 1'b0;
            irq_pci_reg <= 1'b0;
            irq_leg_reg <= 1'b0;
            crst_reg    <= 1'b1;
            tabt_reg    <= 1'b0;
            serr_reg    <= 1'b0;
            perr_reg    <= 1'b0;
        end else if (ce_i) begin
            // merge onto first line when tied
            inta_reg    <= int_req_a_i | (tie_reg & int_req_b_i);
            intb_reg    <= int_req_b_i & ~tie_reg;
            irq_pci_reg <= card_func_irq_i & ~fwd_ctrl_reg[`CBW_FWD_IRQSEL];
            irq_leg_reg <= card_func_irq_i & fwd_ctrl_reg[`CBW_FWD_IRQSEL];
            // card reset from bit or PCI reset
            crst_reg    <= fwd_ctrl_reg[`CBW_FWD_CRST] | pci_reset_input_sync_reg[1];
            tabt_reg    <= card_master_abort_i & fwd_ctrl_reg[`CBW_FWD_MABT];
            serr_reg    <= (card_master_abort_i & fwd_ctrl_reg[`CBW_FWD_MABT] &
                            serr_enable_i) |
                           (cserr_sync_reg[1] & fwd_ctrl_reg[`CBW_FWD_SERR]);
            perr_reg    <= cperr_sync_reg[1] & fwd_ctrl_reg[`CBW_FWD_PERR];
        end
    end

    assign pci_io_claim_o       = io_claim_reg;
    assign card_io_to_pci_o     = io_up_reg;
    assign pci_mem_vga_claim_o  = mem_vga_reg;
    assign pci_inta_o           = inta_reg;
    assign pci_intb_o           = intb_reg;
    assign card_irq_to_pci_o    = irq_pci_reg;
    assign card_irq_to_legacy_o = irq_leg_reg;
    assign card_reset_o         = crst_reg;
    assign pci_target_abort_o   = tabt_reg;
    assign pci_serr_o           = serr_reg;
    assign card_parity_report_o = perr_reg;
    assign write_post_enable_o    = fwd_ctrl_reg[`CBW_FWD_POST];
    assign window0_prefetchable_o = fwd_ctrl_reg[`CBW_FWD_PREF0];
    assign window1_prefetchable_o = fwd_ctrl_reg[`CBW_FWD_PREF1];

endmodule

//--- bench/cbw_window_ctrl_sva.sv
// Port-level checker for the window control register bank
`timescale 1ns/1ps
`include "cbw_regs.vh"
module cbw_window_ctrl_sva (
    input wire        mclk_i,
    input wire        rst_i,
    input wire        hsel_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire        hready_i,
    input wire        hreadyout_o,
    input wire        hresp_o,
    input wire        pci_io_valid_i,
    input wire        pci_io_claim_o,
    input wire        pci_mem_valid_i,
    input wire [31:0] pci_mem_addr_i,
    input wire        pci_mem_vga_claim_o,
    input wire        int_req_b_i,
    input wire        pci_intb_o,
    input wire        card_func_irq_i,
    input wire        card_irq_to_pci_o,
    input wire        card_irq_to_legacy_o,
    input wire        pci_reset_input_n_i,
    input wire        card_reset_o,
    input wire        card_master_abort_i,
    input wire        serr_enable_i,
    input wire        pci_target_abort_o,
    input wire        pci_serr_o,
    input wire        card_syserr_n_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Accepted address phase
    wire take = hsel_i && hready_i && htrans_i[1];
    sequence s_rd_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    a_read_one_wait: assert property (take && !hwrite_i |=> s_rd_wait) else $error("read wait");
    a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o) else $error("write wait");
    a_resp_always_okay: assert property (hresp_o == 1'b0) else $error("resp not okay");
    a_claim_has_cause: assert property (pci_io_claim_o |-> $past(pci_io_valid_i)) else $error("claim");
    a_vga_mem_range: assert property (pci_mem_vga_claim_o |-> $past(pci_mem_valid_i) &&
        $past(pci_mem_addr_i) >= `CBW_VGA_MEM_LO && $past(pci_mem_addr_i) <= `CBW_VGA_MEM_HI)
        else $error("vga claim");
    a_abort_has_cause: assert property (pci_target_abort_o |-> $past(card_master_abort_i))
        else $error("target abort");
    a_serr_has_cause: assert property (pci_serr_o |-> ($past(card_master_abort_i) &&
        $past(serr_enable_i)) || !$past(card_syserr_n_i, 3) || !$past(card_syserr_n_i, 4))
        else $error("serr");
    a_tie_intb_cause: assert property (pci_intb_o |-> $past(int_req_b_i)) else $error("intb");
    a_card_irq_route: assert property (card_irq_to_pci_o |-> !card_irq_to_legacy_o &&
        $past(card_func_irq_i)) else $error("irq route");
    a_pin_reset_card: assert property (!$past(pci_reset_input_n_i, 3) |-> card_reset_o)
        else $error("card reset");
endmodule
bind cbw_window_ctrl cbw_window_ctrl_sva i_sva (.*);

//--- bench/cbw_host_model.sv
// Register bus master standing for the configuration host
`timescale 1ns/1ps
module cbw_host_model (
    input  wire        mclk_i,
    input  wire        hready_i,
    input  wire [31:0] hrdata_i,
    output reg         hsel_o = 1'b0,
    output reg  [31:0] haddr_o = 32'h0,
    output reg  [1:0]  htrans_o = 2'h0,
    output reg         hwrite_o = 1'b0,
    output reg  [2:0]  hsize_o = 3'h2,
    output reg  [31:0] hwdata_o = 32'h5A5A5A5A,
    output reg  [31:0] rd_val_o = 32'h0,
    output reg  [7:0]  rd_cnt_o = 8'h0
);
    // One word transfer; each phase held until ready is sampled high
    task xfer(input w, input [9:0] idx, input [31:0] d);
        begin
            @(posedge mclk_i);
            hsel_o <= 1'b1;
            htrans_o <= 2'h2;
            hwrite_o <= w;
            haddr_o <= {20'h0, idx, 2'h0};
            @(posedge mclk_i);
            while (hready_i !== 1'b1) begin
                @(posedge mclk_i);
            end
            hsel_o <= 1'b0;
            htrans_o <= 2'h0;
            // Idle data lines toggle so a stale value never looks valid
            hwdata_o <= w ? d : ~hwdata_o;
            @(posedge mclk_i);
            while (hready_i !== 1'b1) begin
                @(posedge mclk_i);
            end
            if (!w) begin
                rd_val_o <= hrdata_i;
                rd_cnt_o <= rd_cnt_o + 8'h1;
            end
        end
    endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the window control register bank
`timescale 1ns/1ps
`include "cbw_regs.vh"
module testbench;
    reg         mclk_i = 1'b0;
    reg         rst_i = 1'b1;
    wire        ce_i = 1'b1;
    wire        hsel_i, hwrite_i, hreadyout_o, hresp_o;
    wire [1:0]  htrans_i;
    wire [2:0]  hsize_i;
    wire [31:0] haddr_i, hwdata_i, hrdata_o;
    wire        hready_i = hreadyout_o;
    reg         dv = 1'b0;
    reg  [31:0] da = 32'h0;
    wire        pci_io_valid_i = dv;
    wire        card_io_valid_i = dv;
    wire        pci_mem_valid_i = dv;
    wire [31:0] pci_io_addr_i = da;
    wire [31:0] card_io_addr_i = da;
    wire [31:0] pci_mem_addr_i = da;
    reg         int_req_a_i = 1'b0;
    reg         int_req_b_i = 1'b0;
    reg         card_func_irq_i = 1'b0;
    reg         pci_reset_input_n_i = 1'b1;
    reg         card_master_abort_i = 1'b0;
    reg         serr_enable_i = 1'b1;
    reg         card_syserr_n_i = 1'b1;
    reg         card_parity_err_n_i = 1'b1;
    wire        pci_io_claim_o, card_io_to_pci_o, pci_mem_vga_claim_o, pci_inta_o, pci_intb_o;
    wire        card_irq_to_pci_o, card_irq_to_legacy_o, card_reset_o, pci_target_abort_o;
    wire        pci_serr_o, card_parity_report_o, write_post_enable_o;
    wire        window0_prefetchable_o, window1_prefetchable_o;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     seed = 32'h5ed9;
    integer     k;
    reg  [31:0] exp_q[$];
    reg  [15:0] pg;
    reg  [15:0] v;

    cbw_window_ctrl i_cbw_window_ctrl (.*);
    cbw_host_model i_cbw_host_model (.mclk_i(mclk_i), .hready_i(hready_i), .hrdata_i(hrdata_o),
        .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i),
        .hsize_o(hsize_i), .hwdata_o(hwdata_i), .rd_val_o(), .rd_cnt_o());

    // Clock and watchdog
    always #2.5 mclk_i = ~mclk_i;
    initial begin
        #100000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task wr(input [9:0] i, input [31:0] d);
        i_cbw_host_model.xfer(1'b1, i, d);
    endtask
    task rd(input [9:0] i, input [31:0] e);
        begin
            exp_q.push_back(e);
            i_cbw_host_model.xfer(1'b0, i, 32'h0);
        end
    endtask
    task fwd(input [15:0] d);
        wr(`CBW_IDX_FWD_CTRL, {16'hFFFF, d});
    endtask
    // One decode sample; e is {claim, card to pci, vga memory}
    task io(input [31:0] a, input [2:0] e);
        begin
            @(posedge mclk_i);
            dv <= 1'b1;
            da <= a;
            @(posedge mclk_i);
            dv <= 1'b0;
            #1;
            chk({pci_io_claim_o, card_io_to_pci_o, pci_mem_vga_claim_o}, e);
        end
    endtask
    task late(input integer n);
        begin
            repeat (n) @(posedge mclk_i);
            #1;
        end
    endtask
    // Read results are compared against the oldest note
    always @(i_cbw_host_model.rd_cnt_o) begin
        #1;
        if (exp_q.size() > 0) chk(i_cbw_host_model.rd_val_o, exp_q.pop_front());
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        chk({window1_prefetchable_o, window0_prefetchable_o, write_post_enable_o}, 3'h6);
        chk(card_reset_o, 1'b1);
        rd(`CBW_IDX_IOW0_BOT, 32'h0);
        rd(`CBW_IDX_IOW0_TOP, 32'h0);
        rd(`CBW_IDX_IOW1_BOT, 32'h0);
        rd(`CBW_IDX_IOW1_TOP, 32'h0);
        rd(`CBW_IDX_IRQ_ROUTE, 32'hFF);
        rd(`CBW_IDX_IRQ_PIN, 32'h01);
        rd(`CBW_IDX_FWD_CTRL, 32'h0340);
        rd(`CBW_IDX_BRD_VENDOR, 32'h0);
        rd(`CBW_IDX_BRD_PROD, 32'h0);
        rd(10'h3FF, 32'h0);
        $display("reset values done");
        wr(`CBW_IDX_IOW0_BOT, 32'hFFFFFFFF);
        rd(`CBW_IDX_IOW0_BOT, 32'hFFFFFFFC);
        wr(`CBW_IDX_IOW0_TOP, 32'hFFFFFFFF);
        rd(`CBW_IDX_IOW0_TOP, 32'h0000FFFC);
        fwd(16'hFFFF);
        rd(`CBW_IDX_FWD_CTRL, 32'h07EF);
        chk({window1_prefetchable_o, window0_prefetchable_o, write_post_enable_o}, 3'h7);
        v = $random(seed);
        wr(`CBW_IDX_IRQ_ROUTE, {16'hFFFF, v});
        rd(`CBW_IDX_IRQ_ROUTE, {24'h0, v[7:0]});
        wr(`CBW_IDX_BRD_VENDOR, 32'h1234);
        rd(`CBW_IDX_BRD_VENDOR, 32'h0);
        wr(`CBW_IDX_SYS_CTRL, 32'h0);
        wr(`CBW_IDX_BRD_VENDOR, {16'hFFFF, v});
        rd(`CBW_IDX_BRD_VENDOR, {16'h0, v});
        wr(`CBW_IDX_BRD_PROD, {v, ~v});
        rd(`CBW_IDX_BRD_PROD, {16'h0, ~v});
        fwd(16'h0);
        late(2);
        chk({card_reset_o, window1_prefetchable_o, window0_prefetchable_o}, 3'h0);
        $display("register access done");
        pg = $random(seed);
        wr(`CBW_IDX_IOW0_BOT, {pg, 16'h1000});
        wr(`CBW_IDX_IOW0_TOP, 32'hFFFF10FC);
        io({pg, 16'h0FFC}, 3'h2);
        io({pg, 16'h1000}, 3'h4);
        io({pg, 16'h10FF}, 3'h4);
        io({pg, 16'h1100}, 3'h2);
        io({~pg, 16'h1000}, 3'h2);
        wr(`CBW_IDX_IOW1_BOT, {~pg, 16'h2000});
        wr(`CBW_IDX_IOW1_TOP, 32'h2000);
        io({~pg, 16'h2003}, 3'h4);
        for (k = 0; k < 4; k = k + 1) wr(`CBW_IDX_IOW0_BOT + 4 * k, 32'h0);
        io(32'h0, 3'h2);
        wr(`CBW_IDX_IOW0_TOP, 32'hFFFC);
        fwd(16'h4);
        io(32'h0100, 3'h0);
        io(32'h0400, 3'h4);
        fwd(16'hC);
        io(32'h03C0, 3'h4);
        io(32'h000A0000, 3'h3);
        $display("decode done");
        int_req_b_i <= 1'b1;
        late(2);
        chk({pci_inta_o, pci_intb_o}, 2'h1);
        wr(`CBW_IDX_SYS_CTRL, 32'h20000000); // terminal three serial before tie
        rd(`CBW_IDX_SYS_CTRL, 32'h20000000);
        rd(`CBW_IDX_IRQ_PIN, 32'h01);
        late(1);
        chk({pci_inta_o, pci_intb_o}, 2'h2);
        for (k = 0; k < 3; k = k + 1) begin
            if (k == 1) fwd(16'h2C);
            if (k == 2) serr_enable_i <= 1'b0;
            @(posedge mclk_i);
            card_master_abort_i <= 1'b1;
            @(posedge mclk_i);
            card_master_abort_i <= 1'b0;
            #1;
            chk({pci_target_abort_o, pci_serr_o}, (k == 0) ? 2'h0 : (k == 1) ? 2'h3 : 2'h2);
        end
        fwd(16'h3);
        card_syserr_n_i <= 1'b0;
        card_parity_err_n_i <= 1'b0;
        late(4);
        chk({pci_serr_o, card_parity_report_o}, 2'h3);
        fwd(16'h0);
        late(2);
        chk({pci_serr_o, card_parity_report_o}, 2'h0);
        card_func_irq_i <= 1'b1;
        late(2);
        chk({card_irq_to_pci_o, card_irq_to_legacy_o}, 2'h2);
        fwd(16'h80);
        late(2);
        chk({card_irq_to_pci_o, card_irq_to_legacy_o}, 2'h1);
        pci_reset_input_n_i <= 1'b0;
        late(4);
        chk(card_reset_o, 1'b1);
        $display("side effects done");
        tally_and_finish;
    end
endmodule
